// ==== rtl/bms_defs.svh ====
`ifndef BMS_DEFS_SVH
`define BMS_DEFS_SVH

// register byte offsets on the avalon slave
`define BMS_OFS_CTRL        8'h00
`define BMS_OFS_STATUS      8'h04
`define BMS_OFS_PERIOD0     8'h08
`define BMS_OFS_COUNT0      8'h18
`define BMS_OFS_CYCLES      8'h28
`define BMS_OFS_ID          8'h2c

// control register fields
`define BMS_CTRL_DONE_A     0
`define BMS_CTRL_DONE_BCD   1
`define BMS_CTRL_TEN_LSB    4
`define BMS_CTRL_RESET      32'h0000_0000

// status register fields
`define BMS_STAT_MODE_A     0
`define BMS_STAT_MODE_BCD   3
`define BMS_STAT_STATE_A    8
`define BMS_STAT_STATE_BCD  10

// timer defaults and expired pulse length in clocks
`define BMS_PERIOD_RESET    32'h0000_0000
`define BMS_EXP_CYCLES      3'h4

// identity word, value arbitrary
`define BMS_ID_VALUE        32'h0000_5a01

`endif

// ==== rtl/bms_pkg.sv ====
package bms_pkg;

    // boot mode decoded from one strap group
    typedef enum logic [2:0] {
        BMS_MODE_NONE  = 3'h0,
        BMS_MODE_HOST  = 3'h1,
        BMS_MODE_LINK  = 3'h3,
        BMS_MODE_EPROM = 3'h2,
        BMS_MODE_RSVD  = 3'h6
    } bms_mode_t;

    // boot sequence per strap group, gray along strap-boot-run
    typedef enum logic [1:0] {
        BMS_ST_STRAP = 2'h0,
        BMS_ST_BOOT  = 2'h1,
        BMS_ST_RUN   = 2'h3,
        BMS_ST_HALT  = 2'h2
    } bms_state_t;

    // one set of straps as seen on the pins
    typedef struct packed {
        logic eprom;
        logic link;
        logic sel;
    } bms_strap_t;

    // strap table; select pin is ignored when it acts as an output
    function automatic bms_mode_t bms_decode(input bms_strap_t s);
        bms_mode_t m;
        m = BMS_MODE_RSVD;
        if (s.eprom && !s.link) begin
            m = BMS_MODE_EPROM;
        end else if (!s.eprom && !s.link) begin
            m = s.sel ? BMS_MODE_HOST : BMS_MODE_NONE;
        end else if (!s.eprom && s.link && s.sel) begin
            m = BMS_MODE_LINK;
        end
        return m;
    endfunction

endpackage

// ==== rtl/bms_timer.sv ====
`timescale 1ns/1ps
`include "bms_defs.svh"

// one processor timer: counts down, pulses expired on reaching zero
module bms_timer import bms_pkg::*; #(
    parameter int WIDTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             enable,
    input  wire logic [WIDTH-1:0] period,
    output logic      [WIDTH-1:0] count,
    output logic                  expired
);

    logic [2:0] exp_cnt_reg;    // remaining cycles of the expired pulse

    // count down while enabled, reload from period at zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (ce) begin
            if (!enable) begin
                count <= period;                // idle timer tracks its period
            end else if (count == '0) begin
                count <= period;
            end else begin
                count <= count - 1'b1;
            end
        end
    end

    // expired stands four cycles from each zero reach
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            exp_cnt_reg <= 3'h0;
            expired     <= 1'b0;
        end else if (ce) begin
            if (enable && count == '0) begin
                exp_cnt_reg <= `BMS_EXP_CYCLES - 3'h1;
                expired     <= 1'b1;
            end else if (exp_cnt_reg != 3'h0) begin
                exp_cnt_reg <= exp_cnt_reg - 3'h1;
                expired     <= 1'b1;
            end else begin
                expired     <= 1'b0;
            end
        end
    end

    a_exp_four_cycles: assert property (@(posedge clk) disable iff (rst || !ce)
        $rose(expired) |-> expired [*4] ##1 (!expired || $past(enable && count == '0)))
        else $error("timer expired pulse is not four cycles");

endmodule

// ==== rtl/bms_top.sv ====
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "bms_defs.svh"

module bms_top import bms_pkg::*; #(
    parameter int NUM_TIMERS = 4,
    parameter int TIMER_W    = 32
) (
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    input  wire logic        CLOCK_EN,
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        EPROM_BOOT_STRAP_A,
    input  wire logic        LINK_BOOT_STRAP_A,
    input  wire logic        BOOT_MEM_SELECT_A_IN,
    output logic             BOOT_MEM_SELECT_A_OUT,
    output logic             BOOT_MEM_SELECT_A_OE,
    input  wire logic        BUS_MASTER_A,
    input  wire logic        EPROM_BOOT_STRAP_SHARED,
    input  wire logic        LINK_BOOT_STRAP_SHARED,
    input  wire logic        BOOT_MEM_SELECT_SHARED_IN,
    output logic             BOOT_MEM_SELECT_SHARED_OUT,
    output logic             BOOT_MEM_SELECT_SHARED_OE,
    input  wire logic        BUS_MASTER_SHARED,
    output logic [NUM_TIMERS-1:0] TIMER_EXPIRED_OUT
);

    // group 0 is processor a, group 1 is the shared b/c/d set
    bms_strap_t   strap_pin [2];            // live strap pins per group
    bms_strap_t   strap_reg [2];            // straps caught after reset release
    bms_mode_t    mode_reg  [2];            // decoded boot mode per group
    bms_state_t   state_reg [2];            // boot sequence per group
    logic         caught_reg;               // straps have been caught
    logic         owner     [2];            // bus ownership per group
    logic         sel_out_reg [2];          // select pin level, low = chip select
    logic         sel_oe_reg  [2];          // select pin drive enable
    logic [31:0]  ctrl_reg;                 // done strobes and timer enables
    logic [TIMER_W-1:0] period_reg [NUM_TIMERS];  // timer reload values
    logic [TIMER_W-1:0] count_w    [NUM_TIMERS];  // live timer counts
    logic [NUM_TIMERS-1:0] expired_w;       // timer expired pulses
    logic [31:0]  cycles_reg;               // instruction cycle counter
    logic         wait_reg;                 // registered waitrequest
    logic [31:0]  rdata_reg;                // registered read data
    logic         req;                      // a bus request is standing
    logic         wr_now;                   // write takes effect this edge
    logic [31:0]  rdata_next;               // read mux output
    logic [1:0]   done_pulse;               // software ends a boot load

    // inputs are synchronous to CLOCK, so they are read directly
    assign strap_pin[0] = '{EPROM_BOOT_STRAP_A, LINK_BOOT_STRAP_A,
                            BOOT_MEM_SELECT_A_IN};
    assign strap_pin[1] = '{EPROM_BOOT_STRAP_SHARED, LINK_BOOT_STRAP_SHARED,
                            BOOT_MEM_SELECT_SHARED_IN};
    assign owner[0] = BUS_MASTER_A;
    assign owner[1] = BUS_MASTER_SHARED;

    // avalon handshake: one wait cycle, then the request completes
    assign req        = AVS_READ || AVS_WRITE;
    assign wr_now     = AVS_WRITE && !wait_reg;
    assign done_pulse = wr_now && AVS_ADDRESS == `BMS_OFS_CTRL ?
                        {AVS_WRITEDATA[`BMS_CTRL_DONE_BCD], AVS_WRITEDATA[`BMS_CTRL_DONE_A]}
                        : 2'b00;

    // straps are caught once, one clock after reset release; the board keeps
    // them fixed, so later changes on the pins are not followed
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            caught_reg <= 1'b0;
            for (int g = 0; g < 2; g++) begin
                strap_reg[g] <= '0;
                mode_reg[g]  <= BMS_MODE_NONE;
            end
        end else if (CLOCK_EN && !caught_reg) begin
            caught_reg <= 1'b1;
            for (int g = 0; g < 2; g++) begin
                strap_reg[g] <= strap_pin[g];
                mode_reg[g]  <= bms_decode(strap_pin[g]);
            end
        end
    end

    // boot sequence per group
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            for (int g = 0; g < 2; g++) begin
                state_reg[g] <= BMS_ST_STRAP;
            end
        end else if (CLOCK_EN) begin
            for (int g = 0; g < 2; g++) begin
                unique case (state_reg[g])
                    BMS_ST_STRAP: begin
                        // wait for the straps, then pick the path
                        if (caught_reg) begin
                            unique case (mode_reg[g])
                                BMS_MODE_NONE: state_reg[g] <= BMS_ST_RUN;
                                BMS_MODE_RSVD: state_reg[g] <= BMS_ST_HALT;
                                default:       state_reg[g] <= BMS_ST_BOOT;
                            endcase
                        end
                    end
                    BMS_ST_BOOT: begin
                        // eprom, host or link load runs until software ends it
                        if (done_pulse[g]) begin
                            state_reg[g] <= BMS_ST_RUN;
                        end
                    end
                    BMS_ST_RUN: begin
                        state_reg[g] <= BMS_ST_RUN;
                    end
                    BMS_ST_HALT: begin
                        // reserved straps: stay put, no boot is started
                        state_reg[g] <= BMS_ST_HALT;
                    end
                endcase
            end
        end
    end

    // select pin: chip select during an eprom load, driven only by the
    // bus owner and only in eprom mode; otherwise the pin stays an input
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            for (int g = 0; g < 2; g++) begin
                sel_out_reg[g] <= 1'b1;
                sel_oe_reg[g]  <= 1'b0;
            end
        end else if (CLOCK_EN) begin
            for (int g = 0; g < 2; g++) begin
                sel_oe_reg[g]  <= owner[g] && mode_reg[g] == BMS_MODE_EPROM
                                  && caught_reg;
                sel_out_reg[g] <= !(state_reg[g] == BMS_ST_BOOT
                                  && mode_reg[g] == BMS_MODE_EPROM);
            end
        end
    end

    assign BOOT_MEM_SELECT_A_OUT      = sel_out_reg[0];
    assign BOOT_MEM_SELECT_A_OE       = sel_oe_reg[0];
    assign BOOT_MEM_SELECT_SHARED_OUT = sel_out_reg[1];
    assign BOOT_MEM_SELECT_SHARED_OE  = sel_oe_reg[1];

    // one instruction per clock once processor a runs
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            cycles_reg <= 32'h0000_0000;
        end else if (CLOCK_EN && state_reg[0] == BMS_ST_RUN) begin
            cycles_reg <= cycles_reg + 32'h0000_0001;
        end
    end

    // control and period registers, byte enables honoured
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            ctrl_reg <= `BMS_CTRL_RESET;
            for (int t = 0; t < NUM_TIMERS; t++) begin
                period_reg[t] <= TIMER_W'(`BMS_PERIOD_RESET);
            end
        end else if (CLOCK_EN && wr_now) begin
            for (int b = 0; b < 4; b++) begin
                if (AVS_BYTEENABLE[b] && AVS_ADDRESS == `BMS_OFS_CTRL) begin
                    ctrl_reg[b*8 +: 8] <= AVS_WRITEDATA[b*8 +: 8];
                end
                for (int t = 0; t < NUM_TIMERS; t++) begin
                    if (AVS_BYTEENABLE[b] && AVS_ADDRESS == 8'(`BMS_OFS_PERIOD0 + 4*t)
                        && b*8 < TIMER_W) begin
                        period_reg[t][b*8 +: 8] <= AVS_WRITEDATA[b*8 +: 8];
                    end
                end
            end
        end
    end

    // one timer per processor
    for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tmr
        bms_timer #(.WIDTH(TIMER_W)) u_tmr (
            .clk     (CLOCK),
            .rst     (RESET),
            .ce      (CLOCK_EN),
            .enable  (ctrl_reg[`BMS_CTRL_TEN_LSB + t]),
            .period  (period_reg[t]),
            .count   (count_w[t]),
            .expired (expired_w[t])
        );
    end

    // expired pins come from the timer flops
    assign TIMER_EXPIRED_OUT = expired_w;

    // read mux; unmapped offsets read zero, done bits read zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (AVS_ADDRESS == `BMS_OFS_CTRL) begin
            rdata_next = ctrl_reg & ~32'h0000_0003;
        end else if (AVS_ADDRESS == `BMS_OFS_STATUS) begin
            rdata_next[`BMS_STAT_MODE_A +: 3]    = mode_reg[0];
            rdata_next[`BMS_STAT_MODE_BCD +: 3]  = mode_reg[1];
            rdata_next[`BMS_STAT_STATE_A +: 2]   = state_reg[0];
            rdata_next[`BMS_STAT_STATE_BCD +: 2] = state_reg[1];
        end else if (AVS_ADDRESS == `BMS_OFS_CYCLES) begin
            rdata_next = cycles_reg;
        end else if (AVS_ADDRESS == `BMS_OFS_ID) begin
            rdata_next = `BMS_ID_VALUE;
        end
        for (int t = 0; t < NUM_TIMERS; t++) begin
            if (AVS_ADDRESS == 8'(`BMS_OFS_PERIOD0 + 4*t)) begin
                rdata_next = 32'(period_reg[t]);
            end
            if (AVS_ADDRESS == 8'(`BMS_OFS_COUNT0 + 4*t)) begin
                rdata_next = 32'(count_w[t]);
            end
        end
    end

    // waitrequest drops for one cycle, one edge after the request is seen
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else if (CLOCK_EN) begin
            wait_reg  <= !(req && wait_reg);
            if (AVS_READ && wait_reg) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign AVS_WAITREQUEST = wait_reg;
    assign AVS_READDATA    = rdata_reg;

    a_eprom_chip_sel: assert property (@(posedge CLOCK) disable iff (RESET)
        CLOCK_EN && state_reg[0] == BMS_ST_BOOT && mode_reg[0] == BMS_MODE_EPROM
        |=> !BOOT_MEM_SELECT_A_OUT)
        else $error("eprom load without chip select");
    a_host_wait: assert property (@(posedge CLOCK) disable iff (RESET)
        CLOCK_EN && state_reg[1] == BMS_ST_BOOT && mode_reg[1] == BMS_MODE_HOST
        && !done_pulse[1] |=> state_reg[1] == BMS_ST_BOOT)
        else $error("host boot left without done");
    a_link_no_drive: assert property (@(posedge CLOCK) disable iff (RESET)
        mode_reg[0] == BMS_MODE_LINK |-> ##1 !BOOT_MEM_SELECT_A_OE && BOOT_MEM_SELECT_A_OUT)
        else $error("link boot drives select pin");
    a_none_runs: assert property (@(posedge CLOCK) disable iff (RESET || !CLOCK_EN)
        $rose(caught_reg) && mode_reg[0] == BMS_MODE_NONE |-> ##1 state_reg[0] == BMS_ST_RUN)
        else $error("no-boot mode did not run");
    a_owner_drives: assert property (@(posedge CLOCK) disable iff (RESET)
        $rose(BOOT_MEM_SELECT_SHARED_OE) |-> $past(BUS_MASTER_SHARED))
        else $error("non-owner drives select pin");
    a_float_eprom: assert property (@(posedge CLOCK) disable iff (RESET)
        BOOT_MEM_SELECT_A_OE |-> mode_reg[0] == BMS_MODE_EPROM)
        else $error("select driven outside eprom mode");
    // checked against the shared pins themselves, so a swap with group a shows
    a_shared_decode: assert property (@(posedge CLOCK) disable iff (RESET)
        caught_reg |-> (mode_reg[1] == BMS_MODE_EPROM)
        == (EPROM_BOOT_STRAP_SHARED && !LINK_BOOT_STRAP_SHARED))
        else $error("shared mode mismatch");
    a_cycle_rate: assert property (@(posedge CLOCK) disable iff (RESET)
        CLOCK_EN && state_reg[0] == BMS_ST_RUN |=> cycles_reg == $past(cycles_reg) + 32'h1)
        else $error("cycle count not one per clock");
    a_rsvd_halt: assert property (@(posedge CLOCK) disable iff (RESET)
        caught_reg && mode_reg[1] == BMS_MODE_RSVD |-> ##2 state_reg[1] != BMS_ST_BOOT
        && !BOOT_MEM_SELECT_SHARED_OE)
        else $error("reserved straps started a boot");

endmodule

// ==== bench/bms_board_model.sv ====
`timescale 1ns/1ps

// board side of one boot select pin: strap level plus boot eprom chip select
module bms_board_model (
    input  wire logic sel_out,
    input  wire logic sel_oe,
    input  wire logic strap_level,
    output logic      pin_level,
    output logic      eprom_cs
);
    // device drives the wire when enabled, else the board's tied level shows
    always_comb begin
        if (sel_oe) begin
            pin_level = sel_out;
        end else begin
            pin_level = strap_level;
        end
    end

    // the eprom is selected only while the device pulls the pin low
    assign eprom_cs = sel_oe & ~sel_out;
endmodule

// ==== bench/boot_mode_select_bench.sv ====
`timescale 1ns/1ps
`include "bms_defs.svh"

module boot_mode_select_bench import bms_pkg::*;;
    logic        clock;
    logic        reset;
    logic        clock_en;
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [2:0]  strap_a;     // eprom, link, select level of group a
    logic [2:0]  strap_s;     // same for the shared group
    logic        owner_a;
    logic        owner_s;
    logic        sel_a_out, sel_a_oe, sel_a_pin, cs_a;
    logic        sel_s_out, sel_s_oe, sel_s_pin, cs_s;
    logic [3:0]  expired;
    int          miscompares;
    int          comparisons;
    int          tick;        // free cycle count for rate checks

    // free-running clock; never stopped or retimed
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) tick <= tick + 1;

    bms_top #(.NUM_TIMERS(4), .TIMER_W(32)) i_bms_top (
        .CLOCK(clock), .RESET(reset), .CLOCK_EN(clock_en),
        .AVS_ADDRESS(address), .AVS_READ(read), .AVS_WRITE(write),
        .AVS_WRITEDATA(writedata), .AVS_BYTEENABLE(byteenable),
        .AVS_READDATA(readdata), .AVS_WAITREQUEST(waitrequest),
        .EPROM_BOOT_STRAP_A(strap_a[2]), .LINK_BOOT_STRAP_A(strap_a[1]),
        .BOOT_MEM_SELECT_A_IN(sel_a_pin), .BOOT_MEM_SELECT_A_OUT(sel_a_out),
        .BOOT_MEM_SELECT_A_OE(sel_a_oe), .BUS_MASTER_A(owner_a),
        .EPROM_BOOT_STRAP_SHARED(strap_s[2]), .LINK_BOOT_STRAP_SHARED(strap_s[1]),
        .BOOT_MEM_SELECT_SHARED_IN(sel_s_pin), .BOOT_MEM_SELECT_SHARED_OUT(sel_s_out),
        .BOOT_MEM_SELECT_SHARED_OE(sel_s_oe), .BUS_MASTER_SHARED(owner_s),
        .TIMER_EXPIRED_OUT(expired)
    );

    // one board model per select pin
    bms_board_model i_bms_board_model_a (.sel_out(sel_a_out), .sel_oe(sel_a_oe),
        .strap_level(strap_a[0]), .pin_level(sel_a_pin), .eprom_cs(cs_a));
    bms_board_model i_bms_board_model_s (.sel_out(sel_s_out), .sel_oe(sel_s_oe),
        .strap_level(strap_s[0]), .pin_level(sel_s_pin), .eprom_cs(cs_s));

    // compare and count
    task check(input logic [31:0] seen, input logic [31:0] expct);
        comparisons++;
        if (seen !== expct) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, expct);
        end
    endtask

    // single place where the run ends
    task summarize;
        $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task cycles(input int n);
        repeat (n) @(posedge clock);
    endtask

    // avalon transfer; an edge passes first so strobes never toggle twice
    task bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
             input logic [3:0] be, output logic [31:0] rd);
        int i;
        @(posedge clock);
        read       <= ~wr;
        write      <= wr;
        address    <= adr;
        writedata  <= wd;
        byteenable <= be;
        for (i = 0; i < 20; i++) begin
            @(posedge clock);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        // a slave that never answers ends the run
        if (i == 20) begin
            miscompares++;
            summarize();
        end
    endtask

    task wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, adr, wd, 4'hf, d);
    endtask

    // straps move only while reset is held, as a board would tie them
    task restart(input logic [2:0] sa, input logic [2:0] ss);
        reset   <= 1'b1;
        strap_a <= sa;
        strap_s <= ss;
        cycles(2);
        reset <= 1'b0;
        cycles(5);
    endtask

    // expected mode code from eprom, link and select level
    function automatic logic [2:0] exp_mode(input logic [2:0] s);
        casez (s)
            3'b10?:  return 3'h2;
            3'b000:  return 3'h0;
            3'b001:  return 3'h1;
            3'b011:  return 3'h3;
            default: return 3'h6;
        endcase
    endfunction

    // expected state: reserved halts, no-boot runs, others wait in boot
    function automatic logic [1:0] exp_state(input logic [2:0] m);
        return (m == 3'h6) ? 2'h2 : ((m == 3'h0) ? 2'h3 : 2'h1);
    endfunction

    // pins while reset is held
    task t_reset_values;
        check(32'({expired, sel_s_oe, sel_s_out, sel_a_oe, sel_a_out, waitrequest}),
              32'h0b);
    endtask

    // identity, unmapped place, read-only place, byte lanes
    task t_regs;
        logic [31:0] rd;
        wr(`BMS_OFS_ID, 32'hffff_ffff);
        bus(1'b0, `BMS_OFS_ID, 32'h0, 4'hf, rd);
        check(rd, `BMS_ID_VALUE);
        wr(8'h40, 32'h1234_5678);
        bus(1'b0, 8'h40, 32'h0, 4'hf, rd);
        check(rd, 32'h0);
        bus(1'b1, 8'h0c, 32'haabb_ccdd, 4'h1, rd);
        bus(1'b0, 8'h0c, 32'h0, 4'hf, rd);
        check(rd, 32'h0000_00dd);
    endtask

    // every strap code on both groups; shared group gets the inverted code
    task t_modes;
        logic [31:0] rd;
        logic [2:0]  ma;
        logic [2:0]  ms;
        for (int i = 0; i < 8; i++) begin
            ma = exp_mode(3'(i));
            ms = exp_mode(3'(7 - i));
            restart(3'(i), 3'(7 - i));
            bus(1'b0, `BMS_OFS_STATUS, 32'h0, 4'hf, rd);
            check(32'(rd[5:0]), 32'({ms, ma}));
            check(32'(rd[11:8]), 32'({exp_state(ms), exp_state(ma)}));
            check(32'({sel_s_oe, sel_a_oe}), 32'({ms == 3'h2, ma == 3'h2}));
            check(32'({sel_s_out, sel_a_out}), 32'({ms != 3'h2, ma != 3'h2}));
        end
    endtask

    // bus ownership gates the select output; done bit ends eprom boot
    task t_owner;
        logic [31:0] rd;
        restart(3'b101, 3'b100);
        owner_a <= 1'b0;
        cycles(2);
        check(32'({sel_a_oe, cs_s}), 32'h1);
        owner_a <= 1'b1;
        cycles(2);
        check(32'({sel_a_oe, cs_a}), 32'h3);
        wr(`BMS_OFS_CTRL, 32'h1);
        cycles(2);
        check(32'({sel_a_out, cs_s}), 32'h3);
        bus(1'b0, `BMS_OFS_CTRL, 32'h0, 4'hf, rd);
        check(rd & 32'h3, 32'h0);
        bus(1'b0, `BMS_OFS_STATUS, 32'h0, 4'hf, rd);
        check(32'(rd[11:8]), 32'h7);
        // shared done strobe ends the shared eprom load on its own
        wr(`BMS_OFS_CTRL, 32'h2);
        cycles(2);
        check(32'({sel_s_out, cs_s}), 32'h2);
        bus(1'b0, `BMS_OFS_STATUS, 32'h0, 4'hf, rd);
        check(32'(rd[11:8]), 32'hf);
    endtask

    // run counter follows enabled clock edges one for one
    task t_cycles;
        logic [31:0] c1;
        logic [31:0] c2;
        int          t1;
        bus(1'b0, `BMS_OFS_CYCLES, 32'h0, 4'hf, c1);
        t1 = tick;
        clock_en <= 1'b0;
        cycles(3);
        clock_en <= 1'b1;
        bus(1'b0, `BMS_OFS_CYCLES, 32'h0, 4'hf, c2);
        check(c2 - c1, 32'(tick - t1 - 3));
    endtask

    // timer 0: expired pulse length, then silence once disabled
    task t_timer;
        logic [31:0] rd;
        int          n;
        int          k;
        wr(`BMS_OFS_PERIOD0, 32'h5);
        wr(`BMS_OFS_CTRL, 32'h10);
        k = 0;
        while (expired[0] !== 1'b1 && k < 40) begin
            cycles(1);
            k++;
        end
        check(32'(expired), 32'h1);
        n = 0;
        while (expired[0] === 1'b1 && n < 10) begin
            cycles(1);
            n++;
        end
        check(32'(n), 32'h4);
        wr(`BMS_OFS_CTRL, 32'h0);
        cycles(8);
        n = 0;
        for (k = 0; k < 20; k++) begin
            cycles(1);
            n += (expired !== 4'h0);
        end
        check(32'(n), 32'h0);
        bus(1'b0, `BMS_OFS_COUNT0, 32'h0, 4'hf, rd);
        check(rd, 32'h5);
    endtask

    // main sequence
    initial begin
        clock_en    = 1'b1;
        reset       = 1'b1;
        address     = 8'h00;
        read        = 1'b0;
        write       = 1'b0;
        writedata   = 32'h0;
        byteenable  = 4'hf;
        strap_a     = 3'b000;
        strap_s     = 3'b000;
        owner_a     = 1'b1;
        owner_s     = 1'b1;
        miscompares = 0;
        comparisons = 0;
        cycles(10);
        t_reset_values();
        cycles(10);
        reset <= 1'b0;
        cycles(2);
        t_regs();
        t_modes();
        t_owner();
        t_cycles();
        t_timer();
        summarize();
    end
endmodule
